// [mgf_fifo.sv]
// Purpose: small status FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: no bypass, data appears one cycle after the push
`timescale 1ns/10ps
module mgf_fifo #(
    parameter int W     = 51,
    parameter int DEPTH = 4,
    parameter int PW    = 2
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } mgf_fifo_t;
    mgf_fifo_t s_ff, nxt_s;
    logic push, pop;

    assign in_ready_o  = (s_ff.cnt != (PW+1)'(DEPTH));
    assign out_valid_o = (s_ff.cnt != '0);
    assign out_data_o  = s_ff.mem[s_ff.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data_i;
            nxt_s.wp = s_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.rp = s_ff.rp + 1'b1;
        end
        nxt_s.cnt = s_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// [mgf_grp_tbl.sv]
// Purpose: one-bit group filter table with two synchronous read ports
// Assumes: contents undefined until software fills every entry
// Notes: port a serves frame lookups, port b serves bus reads
`timescale 1ns/10ps
module mgf_grp_tbl #(
    parameter int DEPTH = 32768,
    parameter int IW    = 15
) (
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire logic          wr_en_i,
    input  wire logic [IW-1:0] wr_idx_i,
    input  wire logic          wr_bit_i,
    input  wire logic [IW-1:0] rda_idx_i,
    output logic               rda_bit_o,
    input  wire logic [IW-1:0] rdb_idx_i,
    output logic               rdb_bit_o
);
    logic mem [DEPTH];
    typedef struct packed {
        logic a;
        logic b;
    } mgf_tbl_t;
    mgf_tbl_t s_ff, nxt_s;

    assign rda_bit_o = s_ff.a;
    assign rdb_bit_o = s_ff.b;

    always_comb begin
        nxt_s.a = mem[rda_idx_i];
        nxt_s.b = mem[rdb_idx_i];
    end

    // no reset on the array: it is a memory, not control state
    always_ff @(posedge mclk_i) begin
        if (wr_en_i) begin
            mem[wr_idx_i] <= wr_bit_i;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// [mgf_phy_model.sv]
// Purpose: transmit side of the link partner path for the pause tests
// Assumes: one pause request at a time
// Notes: busy follows hold_i one cycle late, like a frame in flight
`timescale 1ns/10ps
module mgf_phy_model (
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic hold_i,
    input  wire logic tx_pause_req_i,
    output logic      tx_busy_o,
    output logic      tx_pause_ack_o
);
    logic [1:0] dly_ff;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_busy_o      <= 1'b0;
            tx_pause_ack_o <= 1'b0;
            dly_ff         <= 2'h0;
        end else begin
            tx_busy_o      <= hold_i;
            tx_pause_ack_o <= 1'b0;
            // slow answer: pause frame goes out only once the line is free
            if (tx_pause_req_i && !tx_pause_ack_o && !tx_busy_o) begin
                dly_ff <= dly_ff + 2'h1;
                if (dly_ff == 2'h3) begin
                    tx_pause_ack_o <= 1'b1;
                end
            end
        end
    end
endmodule

// [mgf_pkg.sv]
// Purpose: shared constants and types of the group filter and pause block
// Assumes: 50 MHz mclk_i, first destination octet in da[47:40]
// Notes: byte offsets on an 18-bit register space
//
// Functional notes
// (R1) group lookup needs prefix 01:00:5E first
// (R2) index table with da bits 22 to 8
// (R3) table one accepts, zero or mismatch drops
// (R4) 32K one-bit entries, one word each
// (R5) software fills table before enabling filter
// (R6) destination bit 0 set means group
// (R7) software keeps inner checker promiscuous
// (R8) own unicast match while filter runs
// (R9) filter enable clear gives full promiscuous
// (R10) status words carry address and flags
// (R11) separate transmit and receive pause enables
// (R12) pause write requests frame if enabled
// (R13) request waits for frame in progress
// (R14) request sent even while transmitter halted
// (R15) pause address from config word registers
// (R16) check address, type 8808, opcode 0001
// (R17) failed check or disabled: pass normally
// (R18) valid pause halts, sets reject, drops
// (R19) new pause overwrites count, zero ends
// (R20) fixed pause address needs no programming
// (R21) all-ones address is broadcast
// (R22) pause unit is 512 bit times
package mgf_pkg;
    localparam int          AW           = 18;
    localparam logic [17:0] OFS_CTRL     = 18'h00000;
    localparam logic [17:0] OFS_PAUSE    = 18'h00004;
    localparam logic [17:0] OFS_FCC      = 18'h00010;
    localparam logic [17:0] OFS_RCW_LO   = 18'h00014;
    localparam logic [17:0] OFS_RCW_HI   = 18'h00018;
    localparam logic [17:0] OFS_UC_LO    = 18'h00020;
    localparam logic [17:0] OFS_UC_HI    = 18'h00024;
    localparam logic [17:0] OFS_STAT     = 18'h00028;
    localparam int          TBL_SEL_BIT  = 17;
    localparam int          CTRL_EXT_BIT = 12;
    localparam int          FCC_TX_BIT   = 30;
    localparam int          FCC_RX_BIT   = 29;
    localparam int          STAT_REJ_BIT = 28;
    localparam int          STAT_HLT_BIT = 0;
    localparam logic [31:0] CTRL_MASK    = 32'h0000_1000;
    localparam logic [31:0] FCC_MASK     = 32'h6000_0000;
    localparam logic [31:0] HALF_MASK    = 32'h0000_FFFF;
    localparam logic [31:0] REG_RST      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK      = 2'h0;
    localparam logic [1:0]  RESP_ERR     = 2'h2;
    localparam logic [23:0] IP_MC_PFX    = 24'h01005E;
    localparam logic [47:0] PAUSE_DA     = 48'h010000C28001;
    localparam logic [47:0] BCAST_DA     = 48'hFFFFFFFFFFFF;
    localparam logic [15:0] CTRL_TYPE    = 16'h8808;
    localparam logic [15:0] PAUSE_OPC    = 16'h0001;
    localparam int          FLG_BC       = 0;
    localparam int          FLG_GRP      = 1;
    localparam int          FLG_IPG      = 2;
    localparam int          CLK_NS       = 20;
    localparam int          QUANTUM_BITS = 512;
    localparam int          BIT_NS_1G    = 1;
    localparam int          BIT_NS_100M  = 10;
    localparam int          BIT_NS_10M   = 100;
    localparam int          QCYC_1G      = (QUANTUM_BITS * BIT_NS_1G + CLK_NS - 1) / CLK_NS;
    localparam int          QCYC_100M    = (QUANTUM_BITS * BIT_NS_100M + CLK_NS - 1) / CLK_NS;
    localparam int          QCYC_10M     = (QUANTUM_BITS * BIT_NS_10M + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  SPD_1G       = 2'h2;
    localparam logic [1:0]  SPD_100M     = 2'h1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOOK = 2'b01,
        ST_DEC  = 2'b11
    } mgf_state_t;
endpackage

// [mgf_top.sv]
// Purpose: receive group filter, unicast match and pause flow control
// Assumes: one summary per received frame from the inner MAC checker
// Notes: registers on an AXI4-Lite slave, table in upper half of space
`timescale 1ns/10ps
module mgf_top
    import mgf_pkg::*;
#(
    parameter bit BUILD_EXT_GROUP_FILTER = 1'b1,
    parameter int FIFO_DEPTH             = 4
) (
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire logic [AW-1:0] s_axi_awaddr_i,
    input  wire logic          s_axi_awvalid_i,
    output logic               s_axi_awready_o,
    input  wire logic [31:0]   s_axi_wdata_i,
    input  wire logic [3:0]    s_axi_wstrb_i,
    input  wire logic          s_axi_wvalid_i,
    output logic               s_axi_wready_o,
    output logic [1:0]         s_axi_bresp_o,
    output logic               s_axi_bvalid_o,
    input  wire logic          s_axi_bready_i,
    input  wire logic [AW-1:0] s_axi_araddr_i,
    input  wire logic          s_axi_arvalid_i,
    output logic               s_axi_arready_o,
    output logic [31:0]        s_axi_rdata_o,
    output logic [1:0]         s_axi_rresp_o,
    output logic               s_axi_rvalid_o,
    input  wire logic          s_axi_rready_i,
    input  wire logic          rx_frm_valid_i,
    output logic               rx_frm_ready_o,
    input  wire logic          rx_frm_good_i,
    input  wire logic [47:0]   rx_da_i,
    input  wire logic [15:0]   rx_type_i,
    input  wire logic [15:0]   rx_opcode_i,
    input  wire logic [15:0]   rx_param_i,
    output logic               st_valid_o,
    input  wire logic          st_ready_i,
    output logic [31:0]        st_word0_o,
    output logic [31:0]        st_word1_o,
    output logic [31:0]        st_word2_o,
    input  wire logic [1:0]    speed_i,
    input  wire logic          tx_busy_i,
    input  wire logic          tx_pause_ack_i,
    output logic               tx_pause_req_o,
    output logic [15:0]        tx_pause_val_o,
    output logic [47:0]        tx_pause_sa_o,
    output logic               tx_halt_o
);
    typedef struct packed {
        mgf_state_t  st;
        logic        rx_rdy;
        logic        good;
        logic [47:0] da;
        logic [15:0] typ;
        logic [15:0] opc;
        logic [15:0] prm;
        logic [31:0] ctrl;
        logic [31:0] fcc;
        logic [31:0] pval;
        logic [31:0] rcw_lo;
        logic [31:0] rcw_hi;
        logic [31:0] uc_lo;
        logic [31:0] uc_hi;
        logic        rej;
        logic        pend;
        logic        req;
        logic        halt;
        logic [15:0] pcnt;
        logic [11:0] qcnt;
        logic        awr;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arr;
        logic        rpend;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [17:0] raddr;
        logic [31:0] rdata;
    } mgf_top_t;
    mgf_top_t s_ff, nxt_s;

    logic        we, re, tbl_we, ext_on, tbl_bit, tbl_rd_bit;
    logic        grp, bc, ipg, da_hit, pause_hit, pause_take, acc, push, f_rdy;
    logic [47:0] uc_addr;
    logic [31:0] wmask, rd_val;
    logic [2:0]  flags;
    logic [11:0] qlen;
    logic [50:0] f_out;

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] keep);
        return (old & ~(wmask & keep)) | (s_axi_wdata_i & wmask & keep);
    endfunction

    //**************************************************************
    // bus handshakes
    //**************************************************************
    assign we     = s_ff.awr && s_axi_awvalid_i && s_axi_wvalid_i;
    assign re     = s_ff.arr && s_axi_arvalid_i;
    assign wmask  = strb_mask(s_axi_wstrb_i);
    // table bit lives in byte lane 0 of its word
    assign tbl_we = we && s_axi_awaddr_i[TBL_SEL_BIT] && s_axi_wstrb_i[0]; // R4 R5

    //**************************************************************
    // frame classification
    //**************************************************************
    assign uc_addr = {s_ff.uc_hi[15:0], s_ff.uc_lo};
    assign ext_on  = BUILD_EXT_GROUP_FILTER && s_ff.ctrl[CTRL_EXT_BIT];
    assign grp     = s_ff.da[40]; // R6
    assign bc      = (s_ff.da == BCAST_DA); // R21
    assign ipg     = grp && (s_ff.da[47:24] == IP_MC_PFX); // R1
    // fixed pause address is a constant compare, nothing to program
    assign da_hit  = (s_ff.da == PAUSE_DA) || (s_ff.da == uc_addr); // R20
    assign pause_hit = da_hit && (s_ff.typ == CTRL_TYPE)
                    && (s_ff.opc == PAUSE_OPC); // R16
    assign pause_take = (s_ff.st == ST_DEC) && s_ff.good && pause_hit
                     && s_ff.fcc[FCC_RX_BIT]; // R17 R11
    always_comb begin
        if (!ext_on) begin
            acc = 1'b1; // R9
        end else if (bc) begin
            acc = 1'b1;
        end else if (grp) begin
            acc = ipg && tbl_bit; // R3
        end else begin
            acc = (s_ff.da == uc_addr); // R8
        end
    end
    assign push  = (s_ff.st == ST_DEC) && s_ff.good && !pause_take && acc;
    assign flags = {ipg, grp, bc}; // R10

    always_comb begin
        if (speed_i == SPD_1G) begin
            qlen = 12'(QCYC_1G); // R22
        end else if (speed_i == SPD_100M) begin
            qlen = 12'(QCYC_100M);
        end else begin
            qlen = 12'(QCYC_10M);
        end
    end

    //**************************************************************
    // register read mux
    //**************************************************************
    always_comb begin
        rd_val = REG_RST;
        if (s_ff.raddr[TBL_SEL_BIT]) begin
            rd_val[0] = tbl_rd_bit;
        end else if (s_ff.raddr == OFS_CTRL) begin
            rd_val = s_ff.ctrl;
        end else if (s_ff.raddr == OFS_PAUSE) begin
            rd_val = s_ff.pval;
        end else if (s_ff.raddr == OFS_FCC) begin
            rd_val = s_ff.fcc;
        end else if (s_ff.raddr == OFS_RCW_LO) begin
            rd_val = s_ff.rcw_lo;
        end else if (s_ff.raddr == OFS_RCW_HI) begin
            rd_val = s_ff.rcw_hi;
        end else if (s_ff.raddr == OFS_UC_LO) begin
            rd_val = s_ff.uc_lo;
        end else if (s_ff.raddr == OFS_UC_HI) begin
            rd_val = s_ff.uc_hi;
        end else if (s_ff.raddr == OFS_STAT) begin
            rd_val[STAT_REJ_BIT] = s_ff.rej;
            rd_val[STAT_HLT_BIT] = s_ff.halt;
        end
    end

    //**************************************************************
    // next state
    //**************************************************************
    always_comb begin
        nxt_s = s_ff;
        // write channel: ready rises once both halves are offered
        nxt_s.awr = !s_ff.awr && !s_ff.bvalid && s_axi_awvalid_i && s_axi_wvalid_i;
        if (s_ff.bvalid && s_axi_bready_i) begin
            nxt_s.bvalid = 1'b0;
        end
        if (we) begin
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp  = RESP_OK;
            if (s_axi_awaddr_i[TBL_SEL_BIT]) begin
                nxt_s.bresp = RESP_OK;
            end else if (s_axi_awaddr_i == OFS_CTRL) begin
                nxt_s.ctrl = upd(s_ff.ctrl, CTRL_MASK);
            end else if (s_axi_awaddr_i == OFS_PAUSE) begin
                nxt_s.pval = upd(s_ff.pval, HALF_MASK);
            end else if (s_axi_awaddr_i == OFS_FCC) begin
                nxt_s.fcc = upd(s_ff.fcc, FCC_MASK);
            end else if (s_axi_awaddr_i == OFS_RCW_LO) begin
                nxt_s.rcw_lo = upd(s_ff.rcw_lo, '1);
            end else if (s_axi_awaddr_i == OFS_RCW_HI) begin
                nxt_s.rcw_hi = upd(s_ff.rcw_hi, HALF_MASK);
            end else if (s_axi_awaddr_i == OFS_UC_LO) begin
                nxt_s.uc_lo = upd(s_ff.uc_lo, '1);
            end else if (s_axi_awaddr_i == OFS_UC_HI) begin
                nxt_s.uc_hi = upd(s_ff.uc_hi, HALF_MASK);
            end else if (s_axi_awaddr_i == OFS_STAT) begin
                // write one to clear; a new reject below still wins
                if (wmask[STAT_REJ_BIT] && s_axi_wdata_i[STAT_REJ_BIT]) begin
                    nxt_s.rej = 1'b0;
                end
            end else begin
                nxt_s.bresp = RESP_ERR;
            end
        end
        // read channel: one cycle for the table's registered read
        nxt_s.arr = !s_ff.arr && !s_ff.rpend && !s_ff.rvalid && s_axi_arvalid_i;
        if (re) begin
            nxt_s.raddr = s_axi_araddr_i;
            nxt_s.rpend = 1'b1;
        end
        if (s_ff.rpend) begin
            nxt_s.rpend  = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata  = rd_val;
            nxt_s.rresp  = RESP_OK;
            if (!s_ff.raddr[TBL_SEL_BIT] && (s_ff.raddr > OFS_STAT
                || s_ff.raddr[1:0] != 2'h0)) begin
                nxt_s.rresp = RESP_ERR;
            end
        end
        if (s_ff.rvalid && s_axi_rready_i) begin
            nxt_s.rvalid = 1'b0;
        end
        // frame path
        case (s_ff.st)
            ST_IDLE: begin
                if (rx_frm_valid_i && s_ff.rx_rdy) begin
                    nxt_s.good = rx_frm_good_i;
                    nxt_s.da   = rx_da_i;
                    nxt_s.typ  = rx_type_i;
                    nxt_s.opc  = rx_opcode_i;
                    nxt_s.prm  = rx_param_i;
                    nxt_s.st   = ST_LOOK;
                end
            end
            ST_LOOK: begin
                nxt_s.st = ST_DEC;
            end
            ST_DEC: begin
                // a full status FIFO holds the decision and stalls intake
                if (!push || f_rdy) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
        nxt_s.rx_rdy = (nxt_s.st == ST_IDLE);
        // pause timer
        if (s_ff.pcnt != 16'h0000) begin
            if (s_ff.qcnt <= 12'h001) begin
                nxt_s.pcnt = s_ff.pcnt - 16'h0001;
                nxt_s.qcnt = qlen;
            end else begin
                nxt_s.qcnt = s_ff.qcnt - 12'h001;
            end
        end
        if (pause_take) begin
            nxt_s.pcnt = s_ff.prm; // R18 R19
            nxt_s.qcnt = qlen; // R22
            nxt_s.rej  = 1'b1; // R18
        end
        nxt_s.halt = (nxt_s.pcnt != 16'h0000);
        // transmit pause request, independent of our own halt
        if (tx_pause_ack_i) begin
            nxt_s.pend = 1'b0;
        end
        if (we && !s_axi_awaddr_i[TBL_SEL_BIT] && s_axi_awaddr_i == OFS_PAUSE
            && s_ff.fcc[FCC_TX_BIT]) begin
            nxt_s.pend = 1'b1; // R12 R11
        end
        nxt_s.req = nxt_s.pend && (s_ff.req || !tx_busy_i); // R13 R14
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    //**************************************************************
    // submodules
    //**************************************************************
    mgf_grp_tbl #(
        .DEPTH (32768),
        .IW    (15)
    ) u_tbl (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .wr_en_i   (tbl_we),
        .wr_idx_i  (s_axi_awaddr_i[16:2]),
        .wr_bit_i  (s_axi_wdata_i[0]),
        .rda_idx_i (s_ff.da[22:8]), // R2
        .rda_bit_o (tbl_bit),
        .rdb_idx_i (s_axi_araddr_i[16:2]),
        .rdb_bit_o (tbl_rd_bit)
    );

    mgf_fifo #(
        .W     (51),
        .DEPTH (FIFO_DEPTH),
        .PW    ($clog2(FIFO_DEPTH))
    ) u_fifo (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push),
        .in_ready_o  (f_rdy),
        .in_data_i   ({flags, s_ff.da}),
        .out_valid_o (st_valid_o),
        .out_ready_i (st_ready_i),
        .out_data_o  (f_out)
    );

    assign st_word0_o      = {16'h0000, f_out[47:32]}; // R10
    assign st_word1_o      = f_out[31:0];
    assign st_word2_o      = {29'h0, f_out[50:48]};
    assign rx_frm_ready_o  = s_ff.rx_rdy;
    assign s_axi_awready_o = s_ff.awr;
    assign s_axi_wready_o  = s_ff.awr;
    assign s_axi_bvalid_o  = s_ff.bvalid;
    assign s_axi_bresp_o   = s_ff.bresp;
    assign s_axi_arready_o = s_ff.arr;
    assign s_axi_rvalid_o  = s_ff.rvalid;
    assign s_axi_rresp_o   = s_ff.rresp;
    assign s_axi_rdata_o   = s_ff.rdata;
    assign tx_pause_req_o  = s_ff.req;
    assign tx_pause_val_o  = s_ff.pval[15:0];
    assign tx_pause_sa_o   = {s_ff.rcw_hi[15:0], s_ff.rcw_lo}; // R15
    assign tx_halt_o       = s_ff.halt;

    //**************************************************************
    // checks
    //**************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_pfx;
        push && ext_on && grp && !bc |-> s_ff.da[47:24] == IP_MC_PFX;
    endproperty
    a_pfx: assert property (p_pfx) else $error("group accepted off prefix"); // R1
    property p_idx;
        s_ff.st == ST_LOOK && ipg |=> tbl_bit == $past(u_tbl.mem[s_ff.da[22:8]]);
    endproperty
    a_idx: assert property (p_idx) else $error("wrong table entry used"); // R2
    property p_drop;
        s_ff.st == ST_DEC && s_ff.good && ext_on && grp && !bc && !tbl_bit |-> !push;
    endproperty
    a_drop: assert property (p_drop) else $error("cleared entry accepted"); // R3
    property p_flag;
        push |-> flags[FLG_GRP] == s_ff.da[40] && flags[FLG_BC] == (&s_ff.da);
    endproperty
    a_flag: assert property (p_flag) else $error("bad status flags"); // R6
    property p_uc;
        push && ext_on && !grp |-> s_ff.da == uc_addr;
    endproperty
    a_uc: assert property (p_uc) else $error("unicast miss accepted"); // R8
    property p_prom;
        s_ff.st == ST_DEC && s_ff.good && !ext_on && !pause_take |-> push;
    endproperty
    a_prom: assert property (p_prom) else $error("promiscuous frame lost"); // R9
    property p_txen;
        we && s_axi_awaddr_i == OFS_PAUSE && !s_ff.fcc[FCC_TX_BIT] && !s_ff.pend
            |=> !s_ff.pend;
    endproperty
    a_txen: assert property (p_txen) else $error("pause request while disabled"); // R12
    property p_hold;
        tx_busy_i && !s_ff.req |=> !tx_pause_req_o;
    endproperty
    a_hold: assert property (p_hold) else $error("request during busy frame"); // R13
    property p_take;
        pause_take |=> s_ff.rej && s_ff.pcnt == $past(s_ff.prm) && !$past(push);
    endproperty
    a_take: assert property (p_take) else $error("pause frame not acted on"); // R18
    property p_rxoff;
        s_ff.st == ST_DEC && !s_ff.fcc[FCC_RX_BIT] |-> !pause_take;
    endproperty
    a_rxoff: assert property (p_rxoff) else $error("pause taken while disabled"); // R17

    c_push: cover property (push && ext_on && ipg);
    c_take: cover property (pause_take ##1 s_ff.halt);
    c_req:  cover property ($rose(tx_pause_req_o) && tx_halt_o);
    c_full: cover property (push && !f_rdy);
endmodule

// [mgf_top_tb.sv]
// Purpose: self-checking bench of the group filter and pause block
// Assumes: 1G speed, full strobes, bready and rready held high
// Notes: table only partly filled, so lookups use written entries
`timescale 1ns/10ps
module mgf_top_tb;
    import mgf_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, arv = 1'b0, fv = 1'b0, str = 1'b0;
    logic        hold = 1'b0, good = 1'b1, awr, bv, arr, rv, frdy, stv, preq, halt, busy, ack;
    logic [17:0] awa = 18'h0, ara = 18'h0;
    logic [31:0] wd = 32'h0, rdat, d, w0, w1, w2;
    logic [47:0] fda = 48'h0, psa;
    logic [15:0] fty = 16'h0, fop = 16'h0001, fpar = 16'h0, pval;
    logic [1:0]  bresp, rresp, r;
    logic [67:0] rows [7];
    int          errors = 0, n_tests = 0, i, k;
    mgf_top dut (.mclk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(awv),
        .s_axi_wready_o(), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
        .rx_frm_valid_i(fv), .rx_frm_ready_o(frdy), .rx_frm_good_i(good), .rx_da_i(fda),
        .rx_type_i(fty), .rx_opcode_i(fop), .rx_param_i(fpar), .st_valid_o(stv),
        .st_ready_i(str), .st_word0_o(w0), .st_word1_o(w1), .st_word2_o(w2), .speed_i(SPD_1G),
        .tx_busy_i(busy), .tx_pause_ack_i(ack), .tx_pause_req_o(preq), .tx_pause_val_o(pval),
        .tx_pause_sa_o(psa), .tx_halt_o(halt));
    mgf_phy_model phy (.mclk_i(clk), .reset_i(rst), .hold_i(hold), .tx_pause_req_i(preq),
        .tx_busy_o(busy), .tx_pause_ack_o(ack));
    initial forever #10 clk = ~clk;
    // ****************
    // bench tasks
    // ****************
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    // bounded wait for a level at a rising edge
    task automatic till(ref logic s, input logic v);
        int c;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (s !== v && c < 4000);
        if (c == 4000) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] v);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        till(awr, 1'b1);
        awv <= 1'b0;
        till(bv, 1'b1);
    endtask
    task automatic rd(input logic [17:0] a);
        ara <= a;
        arv <= 1'b1;
        till(arr, 1'b1);
        arv <= 1'b0;
        till(rv, 1'b1);
        d = rdat;
        r = rresp;
    endtask
    task automatic frm(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] pr);
        fda <= da;
        fty <= ty;
        fpar <= pr;
        fv <= 1'b1;
        till(frdy, 1'b1);
        fv <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic pop();
        str <= 1'b1;
        @(posedge clk);
        str <= 1'b0;
    endtask
    initial begin
        // rows: destination, type, delivered, flags {ip group, group, broadcast}
        rows = '{{BCAST_DA, 16'h0800, 4'hB}, {48'h01005E123456, 16'h0800, 4'hE},
            {48'h01005E123556, 16'h0800, 4'h0}, {48'h01005F123456, 16'h0800, 4'h0},
            {48'h020000000001, 16'h0800, 4'h8}, {48'h020000000002, 16'h0800, 4'h0},
            {48'h020000000001, CTRL_TYPE, 4'h8}};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("idle", {frdy, halt, preq}, 3'h4);
        wr(OFS_UC_LO, 32'h0000_0001);
        wr(OFS_UC_HI, 32'h0000_0200);
        wr(18'h248D0, 32'h0000_0001);
        wr(18'h248D4, 32'h0000_0000);
        wr(OFS_CTRL, CTRL_MASK);
        for (i = 0; i < 7; i++) begin
            frm(rows[i][67:20], rows[i][19:4], 16'h1);
            chk("deliver", stv, rows[i][3]);
            if (rows[i][3]) begin
                chk("da", {w0, w1}, {16'h0, rows[i][67:20]});
                chk("flags", w2[2:0], rows[i][2:0]);
            end
            pop();
        end
        rd(18'h0003C);
        chk("unmapped", {d, r}, {32'h0, RESP_ERR});
        wr(OFS_CTRL, REG_RST);
        frm(48'h020000000002, 16'h0800, 16'h0);
        chk("promisc", stv, 1'b1);
        pop();
        good <= 1'b0;
        frm(BCAST_DA, CTRL_TYPE, 16'h0);
        chk("bad", stv, 1'b0);
        good <= 1'b1;
        wr(OFS_FCC, FCC_MASK);
        frm(PAUSE_DA, CTRL_TYPE, 16'h1);
        for (k = 0; halt === 1'b1 && k < 100; k++) @(posedge clk);
        chk("quanta", k >= QCYC_1G - 3 && k <= QCYC_1G + 1, 1'b1);
        frm(PAUSE_DA, CTRL_TYPE, 16'h8);
        chk("consume", {stv, halt}, 2'h1);
        rd(OFS_STAT);
        chk("reject", d[STAT_REJ_BIT], 1'b1);
        wr(OFS_RCW_LO, 32'h0A0B_0C0D);
        wr(OFS_RCW_HI, 32'h0000_0E0F);
        hold <= 1'b1;
        wr(OFS_PAUSE, 32'h0000_0005);
        repeat (4) @(posedge clk);
        chk("busywait", preq, 1'b0);
        hold <= 1'b0;
        till(preq, 1'b1);
        chk("ptx", {halt, pval, psa}, {1'b1, 16'h5, 48'h0E0F0A0B0C0D});
        till(preq, 1'b0);
        frm(48'h020000000001, CTRL_TYPE, 16'h0);
        chk("zero", halt, 1'b0);
        wr(OFS_FCC, 32'h2000_0000);
        wr(OFS_PAUSE, 32'h0000_0007);
        repeat (4) @(posedge clk);
        chk("txoff", preq, 1'b0);
        end_of_test();
    end
endmodule
